// ===== core/charger_regs_pkg.sv
// Register map, field layout, reset values and timing constants of the charger control bank
`default_nettype none
package charger_regs_pkg;

  // Register offsets
  localparam logic [7:0] CTRL_IRQ_ADDR   = 8'h06;
  localparam logic [7:0] THERM_VSYS_ADDR = 8'h07;
  localparam logic [7:0] STATE_ILIM_ADDR = 8'h08;
  localparam logic [7:0] FAULT_SHIP_ADDR = 8'h09;

  // Power-on values
  localparam logic [7:0] CTRL_IRQ_RST    = 8'hc0;
  localparam logic [7:0] THERM_VSYS_RST  = 8'h37;
  localparam logic [7:0] STATE_ILIM_RST  = 8'h00;
  localparam logic [7:0] FAULT_SHIP_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  // Control register 0x06 fields
  localparam int THERM_MON_BIT  = 7;
  localparam int SLOWDOWN_BIT   = 6;
  localparam int PASS_OFF_BIT   = 5;
  localparam int MASK_MSB       = 4;

  // Register 0x07 fields
  localparam int BOARD_OT_BIT   = 7;
  localparam int VLOOP_BIT      = 6;
  localparam int THRESH_MSB     = 5;
  localparam int THRESH_LSB     = 4;
  localparam int VSYS_MSB       = 3;

  // Register 0x08 fields
  localparam int WD_FLAG_BIT    = 7;
  localparam int ILIM_REL_BIT   = 6;
  localparam int ILIM_BOOST_BIT = 5;

  // Register 0x09 fields
  localparam int SHIP_MSB       = 7;
  localparam int SHIP_LSB       = 6;

  // Charge phase codes
  localparam logic [1:0] PHASE_DONE = 2'h3;

  // Watchdog timing: one unit is the shortest period, longer periods are multiples
  localparam longint unsigned CLK_HZ        = 40_000_000;
  localparam longint unsigned WD_UNIT_S     = 40;
  localparam longint unsigned WD_UNIT_CYCLES = WD_UNIT_S * CLK_HZ;
  localparam logic [1:0] WD_OFF = 2'h0;

endpackage
`default_nettype wire

// ===== core/timer_link_if.sv
// Signals between the register bank and its watchdog and safety timer helpers
`timescale 1ns/100ps
`default_nettype none
interface timer_link_if;
  logic [1:0] wd_period;
  logic       wd_kick;
  logic       wd_expire;
  logic       tick_in;
  logic       slow_en;
  logic       tick_out;

  modport core   (output wd_period, wd_kick, tick_in, slow_en, input wd_expire, tick_out);
  modport wdog   (input wd_period, wd_kick, output wd_expire);
  modport safety (input tick_in, slow_en, output tick_out);
endinterface
`default_nettype wire

// ===== core/watchdog_timer.sv
// Host watchdog: expires when no register access arrives within the selected period
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer #(
  parameter int unsigned UNIT_CYCLES = 32'(charger_regs_pkg::WD_UNIT_CYCLES)
) (
  input  wire logic    clock,
  input  wire logic    sys_rst,
  timer_link_if.wdog   link
);

  logic [31:0] pre_r;
  logic [2:0]  units_r;
  logic [2:0]  units_needed;

  ////////////////////////////////////////////////////////////////////////////
  // Period select: 01, 10, 11 give one, two, four units
  always_comb
  begin
    case (link.wd_period)
      2'h1:    units_needed = 3'h1;
      2'h2:    units_needed = 3'h2;
      2'h3:    units_needed = 3'h4;
      default: units_needed = 3'h0;
    endcase
  end

  // Unit prescaler and unit counter, cleared by any access or when disabled
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_r     <= 32'h0;
      units_r   <= 3'h0;
      link.wd_expire <= 1'b0;
    end
    else
    begin
      link.wd_expire <= 1'b0;
      if (link.wd_kick || link.wd_period == charger_regs_pkg::WD_OFF)
      begin
        pre_r   <= 32'h0;
        units_r <= 3'h0;
      end
      else if (pre_r == UNIT_CYCLES - 32'h1)
      begin
        pre_r <= 32'h0;
        if (units_r + 3'h1 == units_needed)
        begin
          units_r        <= 3'h0;
          link.wd_expire <= 1'b1;
        end
        else
          units_r <= units_r + 3'h1;
      end
      else
        pre_r <= pre_r + 32'h1;
    end
  end

endmodule
`default_nettype wire

// ===== core/safety_tick_div.sv
// Safety timer tick: passes every tick, or every second one when slowed down
`timescale 1ns/100ps
`default_nettype none
module safety_tick_div (
  input  wire logic    clock,
  input  wire logic    sys_rst,
  timer_link_if.safety link
);

  logic skip_r;

  ////////////////////////////////////////////////////////////////////////////
  // Half rate drops alternate ticks
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      skip_r        <= 1'b0;
      link.tick_out <= 1'b0;
    end
    else
    begin
      link.tick_out <= link.tick_in && !(link.slow_en && skip_r);
      if (link.tick_in)
        skip_r <= link.slow_en ? !skip_r : 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== core/charger_ctrl_status_regs.sv
// Charger control, interrupt mask and status registers at offsets 0x06 to 0x09
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - 0x06 powers up 0xc0; defaults reset all of it, watchdog all but pass-switch bit.
// - Bit 7 of 0x06 enables thermistor monitoring, default on.
// - Bit 6 of 0x06 halves safety timer rate during power path management.
// - Bit 5 of 0x06 turns battery pass switch off; default on.
// - Bits 4..0 of 0x06 mask good, done, phase, thermistor, overvoltage interrupts.
// - Phase moves among idle, pre-charge, charge raise an unmasked interrupt.
// - 0x07 powers up 0x37; bits 7, 6 disable board protection, voltage loop.
// - Bits 5..4 of 0x07 pick thermal threshold 60 to 120 C, default 11.
// - Bits 3..0 of 0x07 set system voltage, default 0111, defaults reset only.
// - Bit 7 of 0x08 reads 1 after watchdog expiry, 0 after power-on.
// - Bit 6 of 0x08 releases input limit; defaults or watchdog reset it.
// - Bit 5 of 0x08 adds 200 mA to the input limit.
// - Bits 4..3 of 0x08 report charge phase, default not charging.
// - Bit 2 of 0x08 shows power path management active.
// - Bits 1, 0 of 0x08 show input good and thermal regulation.
// - Bits 7..6 of 0x09 pick ship entry delay 1 to 8 s, defaults reset only.
// - Bit 5 of 0x09 shows an input fault.
// - Bit 4 of 0x09 shows thermal shutdown.
// - Bits 3, 2 of 0x09 show battery overvoltage and safety timer expiry.
// - Bits 1, 0 of 0x09 show thermistor hot and cold.
// - Watchdog period 00 off, else 40, 80, 160 s; expiry resets fields.
module charger_ctrl_status_regs #(
  parameter int unsigned WD_UNIT_CYCLES = 32'(charger_regs_pkg::WD_UNIT_CYCLES)
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       reg_defaults_rst,
  input  wire logic [1:0] wd_period,
  input  wire logic       charge_timer_tick,
  input  wire logic [1:0] charge_phase,
  input  wire logic       path_management_flag,
  input  wire logic       input_good_flag,
  input  wire logic       thermal_regulation_flag,
  input  wire logic       input_fault_flag,
  input  wire logic       overheat_shutdown_flag,
  input  wire logic       battery_overvoltage_flag,
  input  wire logic       safety_timer_expired_flag,
  input  wire logic [1:0] thermistor_fault_flags,
  output logic            thermistor_monitor_en,
  output logic            timer_slowdown_en,
  output logic            pass_switch_off,
  output logic            board_overtemp_disable,
  output logic            input_voltage_loop_disable,
  output logic      [1:0] thermal_threshold,
  output logic      [3:0] system_voltage_target,
  output logic            input_limit_release,
  output logic            input_limit_boost,
  output logic      [1:0] ship_entry_delay,
  output logic            safety_tick,
  output logic            watchdog_expired_flag,
  output logic            irq_pulse
);

  logic [7:0] ctrl_r;
  logic [7:0] therm_r;
  logic [1:0] ilim_r;
  logic [1:0] ship_r;
  logic       wd_flag_r;
  logic [4:0] state_r;
  logic [5:0] fault_r;
  logic [7:0] rdata_r;
  logic       irq_r;
  logic       wd_hit;
  logic       wr_ctrl;
  logic       wr_therm;
  logic       wr_state;
  logic       wr_fault;
  logic [4:0] irq_events;

  timer_link_if link ();

  ////////////////////////////////////////////////////////////////////////////
  // Helper timers
  watchdog_timer #(
    .UNIT_CYCLES (WD_UNIT_CYCLES)
  ) u_watchdog (
    .clock   (clock),
    .sys_rst (sys_rst),
    .link    (link.wdog)
  );

  safety_tick_div u_safety (
    .clock   (clock),
    .sys_rst (sys_rst),
    .link    (link.safety)
  );

  // Any register access keeps the watchdog quiet
  assign link.wd_period = wd_period;
  assign link.wd_kick   = reg_wr || reg_rd;
  assign link.tick_in   = charge_timer_tick;
  assign link.slow_en   = ctrl_r[charger_regs_pkg::SLOWDOWN_BIT] && path_management_flag;
  assign wd_hit         = link.wd_expire && !reg_defaults_rst;
  assign safety_tick    = link.tick_out;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode for writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  assign wr_ctrl  = reg_wr && hit(reg_addr, charger_regs_pkg::CTRL_IRQ_ADDR);
  assign wr_therm = reg_wr && hit(reg_addr, charger_regs_pkg::THERM_VSYS_ADDR);
  assign wr_state = reg_wr && hit(reg_addr, charger_regs_pkg::STATE_ILIM_ADDR);
  assign wr_fault = reg_wr && hit(reg_addr, charger_regs_pkg::FAULT_SHIP_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Control and interrupt mask register; pass-switch bit survives the watchdog
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_r <= charger_regs_pkg::CTRL_IRQ_RST;
    else if (reg_defaults_rst)
      ctrl_r <= charger_regs_pkg::CTRL_IRQ_RST;
    else if (wd_hit)
    begin
      ctrl_r <= charger_regs_pkg::CTRL_IRQ_RST;
      ctrl_r[charger_regs_pkg::PASS_OFF_BIT] <= ctrl_r[charger_regs_pkg::PASS_OFF_BIT];
    end
    else if (wr_ctrl)
      ctrl_r <= reg_wdata;
  end

  // Thermal and system voltage register; voltage target survives the watchdog
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      therm_r <= charger_regs_pkg::THERM_VSYS_RST;
    else if (reg_defaults_rst)
      therm_r <= charger_regs_pkg::THERM_VSYS_RST;
    else if (wd_hit)
      therm_r[7:4] <= charger_regs_pkg::THERM_VSYS_RST[7:4];
    else if (wr_therm)
      therm_r <= reg_wdata;
  end

  // Input limit tweaks and ship delay; status bits of the same words ignore writes
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ilim_r <= 2'h0;
      ship_r <= 2'h0;
    end
    else
    begin
      if (reg_defaults_rst || wd_hit)
        ilim_r <= 2'h0;
      else if (wr_state)
        ilim_r <= reg_wdata[charger_regs_pkg::ILIM_REL_BIT:charger_regs_pkg::ILIM_BOOST_BIT];
      if (reg_defaults_rst)
        ship_r <= 2'h0;
      else if (wr_fault)
        ship_r <= reg_wdata[charger_regs_pkg::SHIP_MSB:charger_regs_pkg::SHIP_LSB];
    end
  end

  // Watchdog flag: set on expiry, cleared by reading 0x08; expiry wins
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      wd_flag_r <= 1'b0;
    else if (link.wd_expire)
      wd_flag_r <= 1'b1;
    else if (reg_rd && hit(reg_addr, charger_regs_pkg::STATE_ILIM_ADDR))
      wd_flag_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status sampled from the charger every cycle, never from the host
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= 5'h0;
      fault_r <= 6'h0;
    end
    else
    begin
      state_r <= {charge_phase, path_management_flag, input_good_flag, thermal_regulation_flag};
      fault_r <= {input_fault_flag, overheat_shutdown_flag, battery_overvoltage_flag,
                  safety_timer_expired_flag, thermistor_fault_flags};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: good, done, phase, thermistor, battery overvoltage
  always_comb
  begin
    irq_events[4] = input_good_flag != state_r[1];
    irq_events[3] = charge_phase == charger_regs_pkg::PHASE_DONE
                    && state_r[4:3] != charger_regs_pkg::PHASE_DONE;
    irq_events[2] = charge_phase != state_r[4:3] && charge_phase != charger_regs_pkg::PHASE_DONE
                    && state_r[4:3] != charger_regs_pkg::PHASE_DONE;
    irq_events[1] = thermistor_fault_flags != fault_r[1:0];
    irq_events[0] = battery_overvoltage_flag && !fault_r[3];
  end

  // Masked events merge into a one-cycle pulse
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_events & ~ctrl_r[charger_regs_pkg::MASK_MSB:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        charger_regs_pkg::CTRL_IRQ_ADDR:   rdata_r <= ctrl_r;
        charger_regs_pkg::THERM_VSYS_ADDR: rdata_r <= therm_r;
        charger_regs_pkg::STATE_ILIM_ADDR: rdata_r <= {wd_flag_r, ilim_r, state_r};
        charger_regs_pkg::FAULT_SHIP_ADDR: rdata_r <= {ship_r, fault_r};
        default:                           rdata_r <= charger_regs_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // Field outputs
  assign reg_rdata                  = rdata_r;
  assign thermistor_monitor_en      = ctrl_r[charger_regs_pkg::THERM_MON_BIT];
  assign timer_slowdown_en          = ctrl_r[charger_regs_pkg::SLOWDOWN_BIT];
  assign pass_switch_off            = ctrl_r[charger_regs_pkg::PASS_OFF_BIT];
  assign board_overtemp_disable     = therm_r[charger_regs_pkg::BOARD_OT_BIT];
  assign input_voltage_loop_disable = therm_r[charger_regs_pkg::VLOOP_BIT];
  assign thermal_threshold          = therm_r[charger_regs_pkg::THRESH_MSB:charger_regs_pkg::THRESH_LSB];
  assign system_voltage_target      = therm_r[charger_regs_pkg::VSYS_MSB:0];
  assign input_limit_release        = ilim_r[1];
  assign input_limit_boost          = ilim_r[0];
  assign ship_entry_delay           = ship_r;
  assign watchdog_expired_flag      = wd_flag_r;
  assign irq_pulse                  = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  defaults_ctrl_a: assert property (reg_defaults_rst |=> ctrl_r == 8'hc0 && therm_r == 8'h37)
    else $error("defaults reset did not restore control words");
  wd_keeps_pass_a: assert property (wd_hit |=> pass_switch_off == $past(pass_switch_off) && ctrl_r[4:0] == 5'h0)
    else $error("watchdog handling of control word wrong");
  monitor_write_a: assert property (wr_ctrl && !reg_defaults_rst && !wd_hit
                                    |=> thermistor_monitor_en == $past(reg_wdata[7]))
    else $error("thermistor enable did not follow write");
  full_rate_a: assert property (charge_timer_tick && !link.slow_en |=> safety_tick)
    else $error("safety tick lost at full rate");
  half_rate_a: assert property (link.slow_en throughout (charge_timer_tick ##1 charge_timer_tick)
                                |=> !(safety_tick && $past(safety_tick)))
    else $error("safety tick not halved");
  phase_irq_a: assert property (charge_phase == 2'h1 && state_r[4:3] == 2'h0 && !ctrl_r[2] |=> irq_pulse)
    else $error("phase change interrupt missing");
  masked_irq_a: assert property (ctrl_r[4:0] == 5'h1f |=> !irq_pulse)
    else $error("masked interrupt fired");
  vsys_keep_a: assert property (wd_hit |=> system_voltage_target == $past(system_voltage_target))
    else $error("system voltage reset by watchdog");
  wd_flag_a: assert property (link.wd_expire |=> watchdog_expired_flag)
    else $error("watchdog flag not set");
  ro_fault_a: assert property (wr_fault |=> fault_r[3] == $past(battery_overvoltage_flag))
    else $error("status bit taken from host write");

  // Watchdog and defaults reset against the other writable fields
  ilim_wd_a: assert property (wd_hit |=> !input_limit_release && !input_limit_boost)
    else $error("input limit tweaks survived the watchdog");
  ship_keep_a: assert property (wd_hit |=> ship_entry_delay == $past(ship_entry_delay))
    else $error("ship entry delay reset by watchdog");
  pass_defaults_a: assert property (reg_defaults_rst |=> !pass_switch_off)
    else $error("pass switch not restored by defaults reset");

  // Remaining phase moves and status read back
  phase_step_a: assert property (charge_phase == 2'h2 && state_r[4:3] == 2'h1 && !ctrl_r[2] |=> irq_pulse)
    else $error("pre-charge to charge interrupt missing");
  done_irq_a: assert property (charge_phase == 2'h3 && state_r[4:3] == 2'h2 && !ctrl_r[3] |=> irq_pulse)
    else $error("charge done interrupt missing");
  status_read_a: assert property (reg_rd && reg_addr == charger_regs_pkg::STATE_ILIM_ADDR
                                  |=> reg_rdata[4:3] == $past(charge_phase, 2))
    else $error("charge phase read back wrong");
  fault_read_a: assert property (reg_rd && reg_addr == charger_regs_pkg::FAULT_SHIP_ADDR
                                 |=> reg_rdata[5] == $past(input_fault_flag, 2))
    else $error("input fault read back wrong");

  wd_expiry_c:   cover property (link.wd_expire);
  phase_irq_c:   cover property (irq_events[2] ##1 irq_pulse);
  ctrl_write_c:  cover property (wr_ctrl ##1 reg_rd && reg_addr == 8'h06);
  slow_timer_c:  cover property (link.slow_en && charge_timer_tick);
  phase_step_c:  cover property (charge_phase == 2'h2 && state_r[4:3] == 2'h1);

endmodule
`default_nettype wire

// ===== verif/host_model.sv
// Host model issuing register reads and writes on the strobe port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  ////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe; released data shows the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe; data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/charger_ctrl_status_regs_test.sv
// Self-checking bench for the charger control and status register bank
`timescale 1ns/100ps
`default_nettype none
module charger_ctrl_status_regs_test;
  localparam int unsigned WD_CYC = 50;
  logic        clock            = 1'b0;
  logic        sys_rst          = 1'b1;
  logic        reg_defaults_rst = 1'b0;
  logic        charge_timer_tick = 1'b0;
  logic [1:0]  wd_period        = 2'h0;
  logic [10:0] st               = 11'h000;
  logic [31:0] seed             = 32'h000041d0;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [2:0]  ctl_f;
  logic [7:0]  f07;
  logic [1:0]  f08;
  logic [1:0]  f09;
  logic        safety_tick;
  logic        watchdog_expired_flag;
  logic        irq_pulse;
  logic [7:0]  d;
  logic [7:0]  r;
  int          n_errors    = 0;
  int          check_count = 0;
  int          n_tick      = 0;
  int          n_irq       = 0;
  int          cyc         = 0;

  ////////////////////////////////////////////////////////////
  // Clock and instances
  always #12.5 clock = ~clock;

  charger_ctrl_status_regs #(.WD_UNIT_CYCLES(WD_CYC)) DUT (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_defaults_rst(reg_defaults_rst),
    .wd_period(wd_period), .charge_timer_tick(charge_timer_tick), .charge_phase(st[10:9]),
    .path_management_flag(st[8]), .input_good_flag(st[7]), .thermal_regulation_flag(st[6]),
    .input_fault_flag(st[5]), .overheat_shutdown_flag(st[4]), .battery_overvoltage_flag(st[3]),
    .safety_timer_expired_flag(st[2]), .thermistor_fault_flags(st[1:0]),
    .thermistor_monitor_en(ctl_f[2]), .timer_slowdown_en(ctl_f[1]), .pass_switch_off(ctl_f[0]),
    .board_overtemp_disable(f07[7]), .input_voltage_loop_disable(f07[6]),
    .thermal_threshold(f07[5:4]), .system_voltage_target(f07[3:0]), .input_limit_release(f08[1]),
    .input_limit_boost(f08[0]), .ship_entry_delay(f09), .safety_tick(safety_tick),
    .watchdog_expired_flag(watchdog_expired_flag), .irq_pulse(irq_pulse)
  );

  host_model host (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // Pulse counters sampled mid-cycle, and the hang limit
  always @(negedge clock)
  begin
    if (safety_tick === 1'b1)
      n_tick++;
    if (irq_pulse === 1'b1)
      n_irq++;
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////
  // Random source, expectations and comparisons
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] exp08(input logic [7:0] w);
    return {1'b0, w[6:5], st[10:6]};
  endfunction

  function automatic logic [7:0] exp09(input logic [7:0] w);
    return {w[7:6], st[5:0]};
  endfunction

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      n_errors++;
      $display("unexpected pulse count at %0t: got %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk_val(v, exp);
  endtask

  // One interrupt source fired with its mask bit set or clear
  task automatic irq_case(input int b, input logic m);
    logic [10:0] keep;
    keep = st;
    host.wr(8'h06, {3'b110, m ? 5'(5'h01 << b) : 5'h00});
    repeat (3) @(negedge clock);
    n_irq = 0;
    case (b)
      4: st[7] = ~st[7];
      3: st[10:9] = 2'h3;
      2: st[10:9] = 2'h1;
      1: st[0] = ~st[0];
      default: st[3] = 1'b1;
    endcase
    repeat (4) @(negedge clock);
    chk_cnt(n_irq, m ? 0 : 1);
    st = keep;
    repeat (3) @(negedge clock);
  endtask

  // Four base ticks in a row with slowdown and path management set as given
  task automatic tick_case(input logic slow, input logic path_mode, input int exp);
    host.wr(8'h06, {1'b1, slow, 6'h00});
    st[8] = path_mode;
    repeat (2) @(negedge clock);
    n_tick = 0;
    charge_timer_tick = 1'b1;
    repeat (4) @(negedge clock);
    charge_timer_tick = 1'b0;
    repeat (3) @(negedge clock);
    chk_cnt(n_tick, exp);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    rd_chk(8'h06, 8'hc0);
    rd_chk(8'h07, 8'h37);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h05, 8'h00);
    // Random and boundary field values with random status
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
      r = rnd();
      st = {r[2:0], rnd()};
      host.wr(8'h06, d);
      rd_chk(8'h06, d);
      chk_val({5'h00, ctl_f}, {5'h00, d[7:5]});
      host.wr(8'h07, d);
      rd_chk(8'h07, d);
      chk_val(f07, d);
      host.wr(8'h08, d);
      rd_chk(8'h08, exp08(d));
      chk_val({6'h00, f08}, {6'h00, d[6:5]});
      host.wr(8'h09, d);
      rd_chk(8'h09, exp09(d));
      chk_val({6'h00, f09}, {6'h00, d[7:6]});
    end
    // Watchdog expiry after one period of silence: flag clear at 45 cycles, set by 70
    wd_period = 2'h1;
    host.wr(8'h06, 8'hff);
    host.wr(8'h07, 8'h00);
    host.wr(8'h08, 8'h60);
    host.wr(8'h09, 8'hc0);
    repeat (WD_CYC - 5) @(negedge clock);
    chk_val({7'h00, watchdog_expired_flag}, 8'h00);
    repeat (25) @(negedge clock);
    chk_val({7'h00, watchdog_expired_flag}, 8'h01);
    rd_chk(8'h06, 8'he0);
    rd_chk(8'h07, 8'h30);
    rd_chk(8'h08, exp08(8'h00) | 8'h80);
    rd_chk(8'h08, exp08(8'h00));
    rd_chk(8'h09, exp09(8'hc0));
    wd_period = 2'h0;
    // Register-defaults reset restores every writable field
    @(negedge clock);
    reg_defaults_rst = 1'b1;
    @(negedge clock);
    reg_defaults_rst = 1'b0;
    rd_chk(8'h06, 8'hc0);
    rd_chk(8'h07, 8'h37);
    rd_chk(8'h09, exp09(8'h00));
    // Every interrupt source, unmasked then masked
    st = 11'h000;
    repeat (3) @(negedge clock);
    for (int b = 0; b < 5; b++)
    begin
      irq_case(b, 1'b0);
      irq_case(b, 1'b1);
    end
    // Phase walk: pre-charge to charge, then charge to done, phase and done masks open
    st[10:9] = 2'h1;
    repeat (3) @(negedge clock);
    n_irq = 0;
    st[10:9] = 2'h2;
    repeat (4) @(negedge clock);
    chk_cnt(n_irq, 1);
    n_irq = 0;
    st[10:9] = 2'h3;
    repeat (4) @(negedge clock);
    chk_cnt(n_irq, 1);
    st = 11'h000;
    repeat (3) @(negedge clock);
    tick_case(1'b1, 1'b1, 2);
    tick_case(1'b1, 1'b0, 4);
    tick_case(1'b0, 1'b1, 4);
    // Power-on reset in mid-run restores the pass switch as well
    host.wr(8'h06, 8'hff);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    rd_chk(8'h06, 8'hc0);
    end_of_test();
  end
endmodule
`default_nettype wire
